// ==== rtl/tde_pkg.sv ====
// Shared constants, register map and carrier types of the tolerant dual-channel evaluator.
package tde_pkg;

  // ==================== Timing ====================
  // Clock rate of the block in hertz.
  localparam int CLK_FREQ_HZ = 40_000_000;
  // Logic execution cycle in microseconds.
  localparam int EXEC_TIME_US = 4000;
  // Clocks per logic execution cycle.
  localparam int EXEC_CYCLES_DEF = EXEC_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  // Milliseconds added to every timer per execution cycle.
  localparam logic [25:0] EXEC_MS = 26'(EXEC_TIME_US / 1000);
  // Scale of one discrepancy and off delay step in milliseconds.
  localparam logic [25:0] STEP_10MS = 26'h000000A;
  // Scale of one AND-mode step in milliseconds.
  localparam logic [25:0] STEP_1S = 26'h00003E8;
  // Largest legal setting of each time register.
  localparam logic [31:0] DISC_MAX = 32'h00001770;
  localparam logic [31:0] OFFD_MAX = 32'h000003E8;
  localparam logic [31:0] ANDT_MAX = 32'h0000EA60;

  // ==================== Register map ====================
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DISC = 8'h04;
  localparam logic [7:0] OFS_OFFD = 8'h08;
  localparam logic [7:0] OFS_ANDT = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  // Reset values of the writable registers.
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [12:0] DISC_RST = 13'h0000;
  localparam logic [9:0] OFFD_RST = 10'h000;
  localparam logic [15:0] ANDT_RST = 16'h0000;

  // Control register layout, bit 4 downward.
  typedef struct packed {
    logic offDelayUse;
    logic offMonEn;
    logic onMonEn;
    logic andOption;
    logic complementary;
  } tde_ctrl_t;

  // One-hot evaluation states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ACTIVE = 3'h2,
    ST_AND = 3'h4
  } tde_state_t;

  // Field inputs of the block.
  typedef struct packed {
    logic inA;
    logic inB;
    logic actuatorEnabled;
    logic offDelayCtl;
  } tde_pins_t;

  // Result outputs of the block.
  typedef struct packed {
    logic relOut;
    logic discErrA;
    logic discErrB;
    logic fault;
    logic statusA;
    logic statusB;
  } tde_flags_t;

endpackage

// ==== rtl/tde_eval.sv ====
// Tolerant dual-channel evaluator with APB configuration and status.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
//
// Contract
// - Equivalent mode decodes both inputs directly.
// - Complementary mode treats input B inverted.
// - AND-mode limit zero or 1..60000 seconds.
// - Discrepancy time zero or 10 ms..60 s.
// - Discrepancy expiry flags the lagging input.
// - Fault set on monitored direction expiry.
// - Active needs both off and valid timing.
// - Single input toggle never regains Active.
// - Entering Active clears all error flags.
// - AND option chooses sequence or plain AND.
// - Actuator falling edge with release enters AND.
// - Actuator high or timeout ends AND mode.
// - In AND mode one toggle regains release.
// - No discrepancy monitoring in AND mode.
// - Off delay holds release during brief drops.
// - Without off delay release drops immediately.
// - Off delay works in both evaluation modes.
// - Status shows Off while other must drop.
// - Status shows On while delay suppresses off.
module tde_eval #(
  parameter int EXEC_CYCLES = tde_pkg::EXEC_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tde_pkg::tde_pins_t pins,
  output tde_pkg::tde_flags_t flags
);
  import tde_pkg::*;

  // ==================== State ====================
  // Every flip-flop of the block lives in this one record.
  typedef struct packed {
    logic [31:0] divCnt;
    logic tick;
    tde_ctrl_t ctrl;
    logic [12:0] discReg;
    logic [9:0] offReg;
    logic [15:0] andReg;
    logic ready;
    logic slvErr;
    logic [31:0] rdata;
    tde_state_t st;
    logic relOut;
    logic errA;
    logic errB;
    logic fault;
    logic statA;
    logic statB;
    logic offSeenA;
    logic offSeenB;
    logic offPhase;
    logic expFlag;
    logic prevA;
    logic prevB;
    logic actPrev;
    logic [25:0] discT;
    logic [25:0] offT;
    logic [25:0] andT;
  } tde_regs_t;

  tde_regs_t s_q; // Registered state.
  tde_regs_t s_d; // Next state.

  // Helper terms shared by the logic and its checks.
  logic physA; // Input A mapped so that 1 means on.
  logic physB; // Input B mapped so that 1 means on.
  logic dlyEn; // Off delay allowed by setting and pin.
  logic dlyHold; // Off delay currently masking a drop.
  logic effA; // Internal value of input A.
  logic effB; // Internal value of input B.
  logic andEntry; // AND mode entry condition this cycle.
  logic [25:0] discLim; // Discrepancy limit in ms.
  logic [25:0] offLim; // Off delay limit in ms.
  logic [25:0] andLim; // AND-mode limit in ms.
  logic access; // APB access phase present.

  // ==================== Functions ====================
  // Converts a step count to milliseconds.
  function automatic logic [25:0] toMs(input logic [15:0] v, input logic [25:0] k);
    toMs = 26'(26'(v) * k);
  endfunction

  // Adds one execution cycle of time, holding at the top.
  function automatic logic [25:0] satAdd(input logic [25:0] t);
    logic [26:0] sum;
    sum = {1'b0, t} + {1'b0, EXEC_MS};
    satAdd = sum[26] ? 26'h3FFFFFF : sum[25:0];
  endfunction

  // ==================== Combinational ====================
  // Computes the complete next state from the current one.
  always_comb begin
    s_d = s_q;
    access = psel && penable;
    // Discrepancy limit in 10 ms steps.
    discLim = toMs(16'(s_q.discReg), STEP_10MS);
    // Off delay limit in 10 ms steps.
    offLim = toMs(16'(s_q.offReg), STEP_10MS);
    andLim = toMs(s_q.andReg, STEP_1S);
    // Equivalent mode reads input B as it is.
    physA = pins.inA;
    physB = pins.inB;
    if (s_q.ctrl.complementary) begin
      physB = !pins.inB;
    end
    dlyEn = s_q.ctrl.offDelayUse && pins.offDelayCtl;
    // Hold both inputs on while the delay runs.
    dlyHold = dlyEn && s_q.relOut && !(physA && physB) && (offLim != 26'h0) && (s_q.offT < offLim);
    effA = physA || dlyHold;
    effB = physB || dlyHold;
    andEntry = s_q.ctrl.andOption && s_q.actPrev && !pins.actuatorEnabled && s_q.relOut;

    // Divider producing the execution tick.
    s_d.tick = 1'b0;
    if (s_q.divCnt >= 32'(EXEC_CYCLES - 1)) begin
      s_d.divCnt = 32'h00000000;
      s_d.tick = 1'b1;
    end else begin
      s_d.divCnt = s_q.divCnt + 32'h00000001;
    end

    // APB slave: the access phase lasts two cycles.
    s_d.ready = 1'b0;
    s_d.slvErr = 1'b0;
    if (access && !s_q.ready) begin
      // Prepares the answer one cycle into the access phase.
      s_d.ready = 1'b1;
      s_d.rdata = 32'h00000000;
      unique case (paddr)
        OFS_CTRL: s_d.rdata = 32'(s_q.ctrl);
        OFS_DISC: begin
          s_d.rdata = 32'(s_q.discReg);
          s_d.slvErr = pwrite && (pwdata > DISC_MAX);
        end
        OFS_OFFD: begin
          s_d.rdata = 32'(s_q.offReg);
          s_d.slvErr = pwrite && (pwdata > OFFD_MAX);
        end
        OFS_ANDT: begin
          s_d.rdata = 32'(s_q.andReg);
          s_d.slvErr = pwrite && (pwdata > ANDT_MAX);
        end
        OFS_STAT: begin
          s_d.rdata = {22'h000000, s_q.st, s_q.st == ST_AND, s_q.statB, s_q.statA,
                       s_q.fault, s_q.errB, s_q.errA, s_q.relOut};
          s_d.slvErr = pwrite;
        end
        default: s_d.slvErr = 1'b1;
      endcase
    end
    if (access && s_q.ready && pwrite && !s_q.slvErr) begin
      // Write takes effect at the completing edge.
      unique case (paddr)
        OFS_CTRL: s_d.ctrl = tde_ctrl_t'(pwdata[4:0]);
        OFS_DISC: s_d.discReg = pwdata[12:0];
        OFS_OFFD: s_d.offReg = pwdata[9:0];
        OFS_ANDT: s_d.andReg = pwdata[15:0];
        default: s_d.rdata = s_q.rdata;
      endcase
    end

    // Evaluation happens only on the execution tick.
    if (s_q.tick) begin
      s_d.prevA = effA;
      s_d.prevB = effB;
      s_d.actPrev = pins.actuatorEnabled;
      // Off delay timer runs in every mode.
      if (dlyEn && s_q.relOut && !(physA && physB)) begin
        s_d.offT = satAdd(s_q.offT);
      end else begin
        s_d.offT = 26'h0;
      end
      // Remembers which inputs went off since Active.
      s_d.offSeenA = s_q.offSeenA || !effA;
      s_d.offSeenB = s_q.offSeenB || !effB;
      // Both off ends the switch-off phase and a stale expiry.
      if (!effA && !effB) begin
        s_d.offPhase = 1'b0;
        s_d.expFlag = 1'b0;
      end
      // Restart the discrepancy timer on any change.
      if (!(effA ^ effB) || (effA != s_q.prevA) || (effB != s_q.prevB)) begin
        s_d.discT = 26'h0;
      end else begin
        s_d.discT = satAdd(s_q.discT);
      end
      if ((effA ^ effB) && (discLim != 26'h0) && (s_q.discT >= discLim) && !s_q.expFlag && s_q.st != ST_AND) begin
        s_d.expFlag = 1'b1;
        // Flag the input that failed to follow.
        s_d.errA = s_q.errA || (s_q.offPhase ? effA : !effA);
        s_d.errB = s_q.errB || (s_q.offPhase ? effB : !effB);
        // Fault only for a monitored direction.
        s_d.fault = s_q.fault || (s_q.offPhase ? s_q.ctrl.offMonEn : s_q.ctrl.onMonEn);
      end

      unique case (s_q.st)
        ST_IDLE: begin
          // Enter Active only after both were off.
          if (effA && effB && s_d.offSeenA && s_d.offSeenB &&
              !(s_q.ctrl.onMonEn && s_d.expFlag && !s_q.offPhase)) begin
            s_d.st = ST_ACTIVE;
            s_d.errA = 1'b0;
            s_d.errB = 1'b0;
            s_d.fault = 1'b0;
            s_d.expFlag = 1'b0;
            s_d.offSeenA = 1'b0;
            s_d.offSeenB = 1'b0;
          end
        end
        ST_ACTIVE: begin
          // The AND option decides by actuator feedback.
          if (andEntry) begin
            s_d.st = ST_AND;
            s_d.andT = 26'h0;
          end else if (!(effA && effB)) begin
            // Without delay any drop leaves Active now.
            s_d.st = ST_IDLE;
            s_d.offPhase = 1'b1;
          end
        end
        ST_AND: begin
          s_d.andT = satAdd(s_q.andT);
          // Actuator high or time limit ends AND mode.
          if (pins.actuatorEnabled || ((andLim != 26'h0) && (s_q.andT >= andLim))) begin
            if (effA && effB) begin
              s_d.st = ST_ACTIVE;
            end else begin
              // Leaving with a drop needs both off again.
              s_d.st = ST_IDLE;
              s_d.offPhase = 1'b1;
            end
            s_d.offSeenA = 1'b0;
            s_d.offSeenB = 1'b0;
          end
        end
        default: s_d.st = ST_IDLE;
      endcase
      // The discrepancy timer stays clear in AND mode.
      if (s_d.st == ST_AND) begin
        s_d.discT = 26'h0;
      end
      // In AND mode release is the plain AND.
      s_d.relOut = (s_d.st == ST_ACTIVE) || (s_d.st == ST_AND && effA && effB);
      // Report Off while the other input must drop.
      s_d.statA = effA && (s_d.relOut || s_d.offSeenB);
      s_d.statB = effB && (s_d.relOut || s_d.offSeenA);
    end
  end

  // ==================== Registers ====================
  // Registers the whole state with synchronous reset.
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.ctrl <= tde_ctrl_t'(CTRL_RST);
      s_q.discReg <= DISC_RST;
      s_q.offReg <= OFFD_RST;
      s_q.andReg <= ANDT_RST;
      s_q.st <= ST_IDLE;
      s_q.prevA <= 1'b0;
      s_q.prevB <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state flip-flops.
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  // The error flop is only ever set together with ready, so it drives the pin alone.
  assign pslverr = s_q.slvErr;
  assign flags = '{relOut: s_q.relOut, discErrA: s_q.errA, discErrB: s_q.errB,
                   fault: s_q.fault, statusA: s_q.statA, statusB: s_q.statB};

  // ==================== Checks ====================
  // Every check below runs on the one block clock and sleeps during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_release_arming: assert property (
    $rose(s_q.relOut) && $past(s_q.st) == ST_IDLE |-> $past(s_q.offSeenA || !effA) && $past(s_q.offSeenB || !effB)
  ) else $error("release rose without both inputs having been off");

  chk_error_clear: assert property (
    $rose(s_q.relOut) && s_q.st == ST_ACTIVE && $past(s_q.st) == ST_IDLE |-> !s_q.errA && !s_q.errB && !s_q.fault
  ) else $error("error flags not cleared on entry to active");

  chk_tick_only: assert property (
    !s_q.tick |=> $stable(s_q.relOut) && $stable(s_q.fault) && $stable(s_q.st)
  ) else $error("evaluation changed outside the execution tick");

  chk_and_entry: assert property (
    s_q.tick && s_q.st == ST_ACTIVE && andEntry |=> s_q.st == ST_AND
  ) else $error("AND mode not entered on actuator falling edge");

  chk_and_exit: assert property (
    s_q.tick && s_q.st == ST_AND && pins.actuatorEnabled |=> s_q.st != ST_AND
  ) else $error("AND mode kept with actuator feedback high");

  chk_and_nodisc: assert property (
    s_q.st == ST_AND |-> s_q.discT == 26'h0 && $stable(s_q.fault)
  ) else $error("discrepancy monitoring ran in AND mode");

  chk_fault_cause: assert property (
    $rose(s_q.fault) |-> s_q.expFlag && !$past(s_q.expFlag)
  ) else $error("fault set without a discrepancy expiry");

  chk_no_delay: assert property (
    s_q.tick && s_q.st == ST_ACTIVE && !dlyEn && !(physA && physB) && !andEntry |=> !s_q.relOut
  ) else $error("release held without off delay");

  chk_delay_hold: assert property (
    s_q.tick && s_q.st == ST_ACTIVE && dlyHold && !andEntry |=> s_q.relOut
  ) else $error("release dropped while the off delay runs");

  chk_disc_flag: assert property (
    s_q.tick && s_q.st != ST_AND && (effA ^ effB) && (discLim != 26'h0) && (s_q.discT >= discLim) && !s_q.expFlag
    |=> s_q.errA || s_q.errB
  ) else $error("discrepancy expiry left both error flags low");

  chk_single_toggle: assert property (
    s_q.tick && s_q.st == ST_IDLE && (!(s_q.offSeenA || !effA) || !(s_q.offSeenB || !effB)) |=> !s_q.relOut
  ) else $error("release granted after one input toggled");

  chk_plain_option: assert property (
    s_q.st != ST_AND && !s_q.ctrl.andOption |=> s_q.st != ST_AND
  ) else $error("AND mode entered with the option off");

  chk_and_timeout: assert property (
    s_q.tick && s_q.st == ST_AND && (andLim != 26'h0) && (s_q.andT >= andLim)
    |=> s_q.st != ST_AND && $stable(s_q.fault)
  ) else $error("AND mode outlived its time limit");

  chk_and_drop: assert property (
    s_q.tick && s_q.st == ST_AND && !(effA && effB) |=> !s_q.relOut
  ) else $error("release kept high with an input off in AND mode");

  chk_delay_end: assert property (
    s_q.tick && s_q.st == ST_ACTIVE && dlyEn && !(physA && physB) && (s_q.offT >= offLim) && !andEntry
    |=> !s_q.relOut
  ) else $error("release held past the end of the off delay");

  chk_and_delay: assert property (
    s_q.tick && s_q.st == ST_AND && dlyHold && !pins.actuatorEnabled && !((andLim != 26'h0) && (s_q.andT >= andLim))
    |=> s_q.relOut
  ) else $error("off delay ignored in AND mode");

  chk_status_off: assert property (
    s_q.tick && !effA |=> !s_q.statA
  ) else $error("status A shown on while input A reads off");

endmodule

// ==== tb/tde_switch_model.sv ====
// Model of the dual-channel switch pair at the evaluator's field side.
`timescale 1ns/100ps
module tde_switch_model (
  input wire logic complementary,
  input wire logic onA,
  input wire logic onB,
  input wire logic actOn,
  input wire logic delayOn,
  output tde_pkg::tde_pins_t pins
);
  import tde_pkg::*;
  // ==================== Contacts ====================
  // Contact B is wired inverted in the complementary build.
  always_comb begin
    pins.inA = onA;
    pins.inB = onB ^ complementary;
    pins.actuatorEnabled = actOn;
    pins.offDelayCtl = delayOn;
  end
endmodule

// ==== tb/tde_eval_tb_top.sv ====
// Self-checking bench of the tolerant dual-channel evaluator.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin errTotal++; $display("FAIL %s exp %0h got %0h", n, e, g); end end
module tde_eval_tb_top;
  import tde_pkg::*;
  // Short execution cycle keeps the run brief.
  localparam int EC = 20;
  // Ticks land EC*k+5 edges after start; inputs change half a period away from them.
  localparam int ALIGN = (5 + EC / 2) % EC;
  int cyc = 0;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Field commands handed to the switch model.
  logic comp = 1'b0;
  logic onA = 1'b0;
  logic onB = 1'b0;
  logic actOn = 1'b0;
  logic delayOn = 1'b0;
  tde_pins_t pins;
  tde_flags_t flags;
  int errTotal = 0;
  int checksDone = 0;
  logic [31:0] rd;
  logic er;
  logic [31:0] f;

  // ==================== Clock and instances ====================
  // Free-running 40 MHz clock.
  initial begin
    forever #12.5 clk = ~clk;
  end

  // Counts clock edges so that field changes keep a fixed phase to the tick.
  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  tde_switch_model sw (.complementary(comp), .onA(onA), .onB(onB), .actOn(actOn), .delayOn(delayOn), .pins(pins));
  tde_eval #(.EXEC_CYCLES(EC)) dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins), .flags(flags));

  // ==================== Tasks ====================
  // Prints the verdict and ends the run.
  task automatic testDone();
    if (errTotal == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One APB transfer held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 10) begin
        errTotal++;
        testDone();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a register and compares data and error response.
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h00000000);
    `CHK("prdata", e, rd)
    `CHK("pslverr", ee, er)
  endtask

  // Sets both contacts, then lets n execution cycles pass.
  task automatic fld(input logic a, input logic b, input int n);
    repeat ((ALIGN - cyc % EC + EC) % EC) @(posedge clk);
    onA <= a;
    onB <= b;
    repeat (n * EC) @(posedge clk);
  endtask

  // Compares release, both discrepancy errors and fault.
  task automatic fchk(input logic [3:0] e);
    `CHK("flags", e, flags[5:2])
  endtask

  // Brings the pair to Active through a full off phase.
  task automatic arm();
    fld(1'b0, 1'b0, 2);
    fld(1'b1, 1'b1, 2);
  endtask

  // ==================== Main sequence ====================
  initial begin
    void'($urandom(32'h9d16));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    // Reset values, unmapped place and refused values.
    rchk(OFS_CTRL, 32'h00000000, 1'b0);
    rchk(OFS_ANDT, 32'h00000000, 1'b0);
    rchk(OFS_STAT, 32'h00000080, 1'b0);
    rchk(8'h14, 32'h00000000, 1'b1);
    apb(1'b1, OFS_DISC, DISC_MAX + 32'h1);
    `CHK("discMax", 1'b1, er)
    apb(1'b1, OFS_ANDT, ANDT_MAX + 32'h1);
    `CHK("andtMax", 1'b1, er)
    apb(1'b1, OFS_OFFD, OFFD_MAX);
    rchk(OFS_OFFD, OFFD_MAX, 1'b0);
    apb(1'b1, OFS_DISC, 32'h00000001);
    // Sequence checks in both input modes.
    for (int c = 0; c < 2; c++) begin
      comp <= c[0];
      apb(1'b1, OFS_CTRL, {31'h0, c[0]} | 32'h0000000C);
      fld(1'b0, 1'b0, 2);
      f = $urandom % 2;
      fld(f[0], ~f[0], 1);
      fld(1'b1, 1'b1, 2);
      fchk(4'h8);
      `CHK("status", 2'h3, flags[1:0])
      fld(1'b0, 1'b1, 2);
      fchk(4'h0);
      fld(1'b1, 1'b1, 2);
      fchk(4'h0);
      `CHK("statusA", 1'b0, flags[1])
      fld(1'b0, 1'b1, 5);
      fchk(4'h3);
      fld(1'b0, 1'b0, 2);
      fld(1'b0, 1'b1, 5);
      fld(1'b1, 1'b1, 2);
      fchk(4'h7);
      arm();
      fchk(4'h8);
    end
    // Monitoring disabled flags the lagging input without fault.
    comp <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h00000000);
    arm();
    fld(1'b0, 1'b1, 5);
    fchk(4'h2);
    // AND mode entry, single toggle and exit.
    apb(1'b1, OFS_CTRL, 32'h0000000E);
    actOn <= 1'b1;
    arm();
    actOn <= 1'b0;
    fld(1'b1, 1'b1, 2);
    rchk(OFS_STAT, 32'h00000271, 1'b0);
    fld(1'b0, 1'b1, 5);
    fchk(4'h0);
    fld(1'b1, 1'b1, 2);
    fchk(4'h8);
    actOn <= 1'b1;
    fld(1'b1, 1'b1, 2);
    rchk(OFS_STAT, 32'h00000131, 1'b0);
    apb(1'b1, OFS_ANDT, 32'h00000001);
    actOn <= 1'b0;
    fld(1'b1, 1'b1, 2);
    `CHK("andOn", 1'b1, dut.flags[5])
    fld(1'b1, 1'b1, 260);
    apb(1'b0, OFS_STAT, 32'h00000000);
    `CHK("andTimeout", 2'h0, {rd[6], rd[3]})
    // Off delay in sequence mode and in AND mode.
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, OFS_CTRL, 32'h00000010 | {30'h0, m[0], 1'b0});
      apb(1'b1, OFS_OFFD, 32'h00000005);
      actOn <= 1'b1;
      delayOn <= 1'b1;
      arm();
      actOn <= m[0] ? 1'b0 : 1'b1;
      fld(1'b0, 1'b1, 2);
      `CHK("holdRel", 2'h3, {flags[5], flags[1]})
      fld(1'b1, 1'b1, 2);
      fld(1'b0, 1'b1, 20);
      `CHK("dropRel", 1'b0, flags[5])
    end
    delayOn <= 1'b0;
    actOn <= 1'b1;
    arm();
    fld(1'b1, 1'b0, 2);
    `CHK("noDelay", 1'b0, flags[5])
    testDone();
  end
endmodule
